// ### hdl/dps_pkg.sv
// Constants, register map and carrier types of the drive protection supervisor.
// Assumes one 100 MHz core clock and an APB master with 32-bit data.
package dps_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_LIM  = 8'h04;
  localparam logic [7:0] OFS_TIM  = 8'h08;
  localparam logic [7:0] OFS_REF  = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam int         CTRL_CLEAR_BIT = 0;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [4:0] RLY_DRV_OL   = 5'h06;
  localparam logic [4:0] RLY_STALL    = 5'h07;
  localparam logic [4:0] RLY_REF_LOSS = 5'h0B;
  localparam logic [4:0] RLY_STOPPED  = 5'h0D;
  localparam logic [4:0] RLY_CONSTANT = 5'h0E;
  localparam logic [4:0] RLY_WAIT_RUN = 5'h10;
  localparam logic [4:0] RLY_FAULT    = 5'h11;
  localparam logic [4:0] FN_EXT_NO    = 5'h12;
  localparam logic [4:0] FN_EXT_NC    = 5'h13;
  localparam logic [1:0] CRIT_HALF    = 2'h1;
  localparam logic [1:0] CRIT_MIN     = 2'h2;
  localparam logic [1:0] ACT_COAST    = 2'h1;
  localparam logic [1:0] ACT_DECEL    = 2'h2;

  // Trip vector positions
  localparam int TRIP_W = 9;
  localparam int TR_UV = 0, TR_MOL = 1, TR_DOL = 2, TR_GND = 3, TR_INPH = 4;
  localparam int TR_OUTPH = 5, TR_EXTA = 6, TR_EXTB = 7, TR_REF = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int TENTH_SEC_MS  = 100;
  localparam int TENTH_CYCLES  = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam logic [12:0] TENTHS_PER_SEC = 13'h000A;
  // Drive overload budget: 50 percent excess held for 600 tenths
  localparam logic [15:0] DOL_BUDGET_MUL = 16'h012C;
  localparam logic [31:0] PCT_SCALE      = 32'h00000064;

  // ---------------------------------------------------------------
  // Carriers and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] in5_fn;       // multi_input_five_function
    logic [4:0] in4_fn;       // multi_input_four_function
    logic [1:0] loss_action;  // reference_loss_action
    logic [1:0] loss_crit;    // analog_loss_criterion
    logic       ovl_en;       // motor_overload_enable
    logic [2:0] user_mask;    // user_fault_mask
    logic [2:0] stall_mask;   // stall_phase_mask
    logic [2:0] fault_mask;   // fault_relay_mask
    logic [4:0] relay_fn;     // relay_function_select
  } dps_cfg_type;

  typedef struct packed {
    logic [15:0] rated;       // motor_rated_current
    logic [7:0]  stall_lvl;   // stall_current_level
    logic [7:0]  ovl_lvl;     // motor_overload_level
  } dps_lim_type;

  typedef struct packed {
    logic [10:0] ref_wait;    // reference_loss_wait, tenths of a second
    logic [7:0]  ovl_time;    // motor_overload_time, seconds
  } dps_tim_type;

  typedef struct packed {
    logic [15:0] drv_rated;   // drive rated current
    logic [7:0]  cur_min;     // current_input_minimum
    logic [7:0]  volt_min;    // voltage_input_minimum
  } dps_ref_type;

  typedef struct packed {
    logic        run_cmd;
    logic        running;
    logic        accel;
    logic        decel;
    logic        gnd_fault;
    logic        in_phase_loss;
    logic        out_phase_loss;
    logic        in4_closed;   // multi_input_four against input_common_terminal
    logic        in5_closed;   // multi_input_five against input_common_terminal
    logic        dc_link_high;
    logic        undervoltage;
    logic        ref_is_analog;
    logic        analog_is_current;
    logic        serial_ref_lost;
    logic        restart_tries;  // auto_restart_tries non-zero
    logic [7:0]  analog_pct;
    logic [15:0] out_current;
  } dps_pin_type;

  typedef struct packed {
    logic out_cut;
    logic stall_decel;
    logic decel_hold;
    logic ramp_extend;
    logic stop_decel;
    logic relay;        // drives relay_normally_open_pair
  } dps_act_type;

  typedef struct packed {
    dps_pin_type         sync1;
    dps_pin_type         sync2;
    dps_cfg_type         cfg;
    dps_lim_type         lim;
    dps_tim_type         tim;
    dps_ref_type         rf;
    logic [23:0]         tick_cnt;
    logic [12:0]         ovl_cnt;
    logic [31:0]         dol_acc;
    logic [10:0]         ref_cnt;
    logic                ref_lost;
    logic [TRIP_W-1:0]   trip;
    dps_act_type         act;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } dps_state_type;

  localparam dps_cfg_type CFG_RST = '{in5_fn: 5'h04, in4_fn: 5'h03, loss_action: 2'h0,
    loss_crit: 2'h0, ovl_en: 1'h0, user_mask: 3'h0, stall_mask: 3'h3,
    fault_mask: 3'h2, relay_fn: 5'h11};
  localparam dps_lim_type LIM_RST = '{rated: 16'h03E8, stall_lvl: 8'h96, ovl_lvl: 8'hB4};
  localparam dps_tim_type TIM_RST = '{ref_wait: 11'h00A, ovl_time: 8'h3C};
  localparam dps_ref_type REF_RST = '{drv_rated: 16'h03E8, cur_min: 8'h00, volt_min: 8'h00};

endpackage

// ### hdl/dps_top.sv
// Drive protection supervisor: trips, stall prevention, reference loss, relay.
// Assumes APB master on CORE_CLK; sense pins are asynchronous and resynchronised.
`timescale 1ns/1ns
module dps_top
  import dps_pkg::*;
#(
  parameter int TICK_CYCLES = TENTH_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  input  wire dps_pin_type SENSE,
  output      dps_act_type DRIVE
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // One input trips only for the contact kind its function code selects
  function automatic logic ext_trip(input logic [4:0] code, input logic closed,
                                    input logic [4:0] kind);
    ext_trip = (code == kind) && (closed == (kind == FN_EXT_NO));
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  dps_state_type st_ff;
  dps_state_type nxt_st;

  dps_pin_type        p;
  logic [31:0]        cur_pct;
  logic               over_ovl;
  logic               over_stall;
  logic               over_drive;
  logic               tick;
  logic [12:0]        ovl_limit;
  logic               analog_loss;
  logic               ref_loss_now;
  logic [7:0]         ref_min;
  logic [TRIP_W-1:0]  cause;
  logic               stall_acc;
  logic               stall_run;
  logic               stall_dec;
  logic               clear_wr;
  logic               mapped;
  logic               fault_relay;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = SENSE;
    nxt_st.sync2 = st_ff.sync1;
    p            = st_ff.sync2;

    tick = (st_ff.tick_cnt == 24'(TICK_CYCLES - 1));
    nxt_st.tick_cnt = tick ? 24'h000000 : st_ff.tick_cnt + 24'h000001;

    // Current compared as percent of rated, scaled to avoid a divider
    cur_pct    = 32'(p.out_current) * PCT_SCALE;
    over_ovl   = cur_pct > (32'(st_ff.lim.rated) * 32'(st_ff.lim.ovl_lvl));
    over_stall = cur_pct > (32'(st_ff.lim.rated) * 32'(st_ff.lim.stall_lvl));
    over_drive = p.out_current > st_ff.rf.drv_rated;

    // Motor overload timer in tenths of a second
    ovl_limit = 13'(st_ff.tim.ovl_time) * TENTHS_PER_SEC;
    if (st_ff.cfg.ovl_en && over_ovl) begin
      if (tick && (st_ff.ovl_cnt < ovl_limit)) begin
        nxt_st.ovl_cnt = st_ff.ovl_cnt + 13'h0001;
      end
    end else begin
      nxt_st.ovl_cnt = 13'h0000;
    end

    // Inverse time: excess current integrates, so more excess trips sooner
    if (over_drive) begin
      if (tick) begin
        nxt_st.dol_acc = st_ff.dol_acc + 32'(p.out_current - st_ff.rf.drv_rated);
      end
    end else begin
      nxt_st.dol_acc = 32'h00000000;
    end

    // Reference loss detection and qualification
    ref_min = p.analog_is_current ? st_ff.rf.cur_min : st_ff.rf.volt_min;
    case (st_ff.cfg.loss_crit)
      CRIT_HALF: analog_loss = ({p.analog_pct, 1'b0} < {1'b0, ref_min});
      CRIT_MIN:  analog_loss = (p.analog_pct < ref_min);
      default:   analog_loss = 1'b0;
    endcase
    ref_loss_now = p.ref_is_analog ? analog_loss : p.serial_ref_lost;
    if (ref_loss_now) begin
      if (tick && (st_ff.ref_cnt < st_ff.tim.ref_wait)) begin
        nxt_st.ref_cnt = st_ff.ref_cnt + 11'h001;
      end
    end else begin
      nxt_st.ref_cnt = 11'h000;
    end
    nxt_st.ref_lost = ref_loss_now && (st_ff.ref_cnt >= st_ff.tim.ref_wait);

    // Trip causes
    cause           = '0;
    cause[TR_UV]    = p.undervoltage;
    cause[TR_MOL]   = st_ff.cfg.ovl_en && over_ovl && (st_ff.ovl_cnt >= ovl_limit);
    cause[TR_DOL]   = st_ff.dol_acc >= (32'(st_ff.rf.drv_rated) * 32'(DOL_BUDGET_MUL));
    cause[TR_GND]   = st_ff.cfg.user_mask[2] && p.running && p.gnd_fault;
    cause[TR_INPH]  = st_ff.cfg.user_mask[1] && p.in_phase_loss;
    cause[TR_OUTPH] = st_ff.cfg.user_mask[0] && p.out_phase_loss;
    cause[TR_EXTA]  = ext_trip(st_ff.cfg.in4_fn, p.in4_closed, FN_EXT_NO) ||
                      ext_trip(st_ff.cfg.in5_fn, p.in5_closed, FN_EXT_NO);
    cause[TR_EXTB]  = ext_trip(st_ff.cfg.in4_fn, p.in4_closed, FN_EXT_NC) ||
                      ext_trip(st_ff.cfg.in5_fn, p.in5_closed, FN_EXT_NC);
    cause[TR_REF]   = st_ff.ref_lost && (st_ff.cfg.loss_action == ACT_COAST);

    // APB
    mapped   = hit(PADDR, OFS_CFG) || hit(PADDR, OFS_LIM) || hit(PADDR, OFS_TIM) ||
               hit(PADDR, OFS_REF) || hit(PADDR, OFS_CTRL) || hit(PADDR, OFS_STAT);
    clear_wr = PSEL && PENABLE && st_ff.pready && PWRITE && hit(PADDR, OFS_CTRL) &&
               PWDATA[CTRL_CLEAR_BIT];
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h00000000;
    if (PSEL && !PENABLE) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !mapped;
      if (!PWRITE) begin
        if (hit(PADDR, OFS_CFG)) begin
          nxt_st.prdata = 32'(st_ff.cfg);
        end else if (hit(PADDR, OFS_LIM)) begin
          nxt_st.prdata = 32'(st_ff.lim);
        end else if (hit(PADDR, OFS_TIM)) begin
          nxt_st.prdata = 32'(st_ff.tim);
        end else if (hit(PADDR, OFS_REF)) begin
          nxt_st.prdata = 32'(st_ff.rf);
        end else if (hit(PADDR, OFS_STAT)) begin
          nxt_st.prdata = 32'({st_ff.act, st_ff.ref_lost, st_ff.trip});
        end
      end
    end
    if (PSEL && PENABLE && st_ff.pready && PWRITE) begin
      if (hit(PADDR, OFS_CFG)) begin
        nxt_st.cfg = dps_cfg_type'(PWDATA[$bits(dps_cfg_type)-1:0]);
      end else if (hit(PADDR, OFS_LIM)) begin
        nxt_st.lim = dps_lim_type'(PWDATA);
      end else if (hit(PADDR, OFS_TIM)) begin
        nxt_st.tim = dps_tim_type'(PWDATA[$bits(dps_tim_type)-1:0]);
      end else if (hit(PADDR, OFS_REF)) begin
        nxt_st.rf = dps_ref_type'(PWDATA);
      end
    end

    // Latched trips: a clear only drops causes already gone, set wins
    nxt_st.trip = (clear_wr ? '0 : st_ff.trip) | cause;
    if (clear_wr) begin
      nxt_st.act.stop_decel = st_ff.ref_lost && (st_ff.cfg.loss_action == ACT_DECEL);
    end else if (st_ff.ref_lost && (st_ff.cfg.loss_action == ACT_DECEL)) begin
      nxt_st.act.stop_decel = 1'b1;
    end
    nxt_st.act.out_cut = |nxt_st.trip;

    // Stall prevention
    stall_acc = st_ff.cfg.stall_mask[0] && p.accel && over_stall;
    stall_run = st_ff.cfg.stall_mask[1] && p.running && !p.accel && !p.decel &&
                over_stall;
    stall_dec = st_ff.cfg.stall_mask[2] && p.decel && p.dc_link_high;
    nxt_st.act.stall_decel = (stall_acc || stall_run) && !nxt_st.act.out_cut;
    nxt_st.act.decel_hold  = stall_dec && !nxt_st.act.out_cut;
    nxt_st.act.ramp_extend = (stall_acc || stall_dec) && !nxt_st.act.out_cut;

    // Multi-function relay
    fault_relay = (st_ff.cfg.fault_mask[0] && st_ff.trip[TR_UV]) ||
                  (st_ff.cfg.fault_mask[1] && (|st_ff.trip[TRIP_W-1:1])) ||
                  (st_ff.cfg.fault_mask[2] && p.restart_tries);
    case (st_ff.cfg.relay_fn)
      RLY_DRV_OL:   nxt_st.act.relay = st_ff.trip[TR_DOL];
      RLY_STALL:    nxt_st.act.relay = stall_acc || stall_run || stall_dec;
      RLY_REF_LOSS: nxt_st.act.relay = st_ff.ref_lost;
      RLY_STOPPED:  nxt_st.act.relay = !p.running && !p.run_cmd;
      RLY_CONSTANT: nxt_st.act.relay = p.running && !p.accel && !p.decel;
      RLY_WAIT_RUN: nxt_st.act.relay = !(|st_ff.trip) && !p.run_cmd && !p.running;
      RLY_FAULT:    nxt_st.act.relay = fault_relay;
      default:      nxt_st.act.relay = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff          <= '0;
      st_ff.cfg      <= CFG_RST;
      st_ff.lim      <= LIM_RST;
      st_ff.tim      <= TIM_RST;
      st_ff.rf       <= REF_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA  = st_ff.prdata;
  assign PREADY  = st_ff.pready;
  assign PSLVERR = st_ff.pslverr;
  assign DRIVE   = st_ff.act;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_ground_seen;
    st_ff.cfg.user_mask[2] && st_ff.sync2.running && st_ff.sync2.gnd_fault;
  endsequence
  sequence s_cut_held;
    DRIVE.out_cut [*2];
  endsequence

  a_apb_setup_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("pready missing after setup");
  a_relay_stop: assert property (
    (st_ff.cfg.relay_fn == RLY_STOPPED) && !st_ff.sync2.running && !st_ff.sync2.run_cmd
    |=> DRIVE.relay)
    else $error("relay not on while stopped");
  a_relay_constant: assert property (
    (st_ff.cfg.relay_fn == RLY_CONSTANT) && (st_ff.sync2.accel || st_ff.sync2.decel)
    |=> !DRIVE.relay)
    else $error("relay on during ramp");
  a_relay_fault_mask: assert property (
    (st_ff.cfg.relay_fn == RLY_FAULT) && (st_ff.cfg.fault_mask == 3'h2) &&
    (st_ff.trip == (TRIP_W'(1) << TR_UV)) && !st_ff.sync2.restart_tries |=> !DRIVE.relay)
    else $error("relay on for undervoltage only");
  a_stall_accel: assert property (
    stall_acc && !nxt_st.act.out_cut |=> DRIVE.stall_decel && DRIVE.ramp_extend)
    else $error("no decel on accel stall");
  a_stall_decel_hold: assert property (
    stall_dec && !nxt_st.act.out_cut |=> DRIVE.decel_hold)
    else $error("decel not paused");
  a_ground_trip: assert property (s_ground_seen ##1 !clear_wr |-> s_cut_held)
    else $error("ground fault not latched");
  a_ext_no_trip: assert property (
    (st_ff.cfg.in4_fn == FN_EXT_NO) && st_ff.sync2.in4_closed |=> DRIVE.out_cut)
    else $error("normally open trip ignored");
  a_ext_nc_trip: assert property (
    (st_ff.cfg.in5_fn == FN_EXT_NC) && !st_ff.sync2.in5_closed |=> DRIVE.out_cut)
    else $error("normally closed trip ignored");
  a_loss_decel: assert property (
    (st_ff.ref_lost && (st_ff.cfg.loss_action == ACT_DECEL)) ##1 !clear_wr
    |-> DRIVE.stop_decel [*2])
    else $error("no decel to stop");
  a_trip_latched: assert property (
    DRIVE.out_cut && !clear_wr |=> DRIVE.out_cut)
    else $error("trip dropped without clear");

endmodule

// ### tb/dps_plant_model.sv
// Far-side model: power stage, run sequence and trip contacts of the drive.
// Assumes the bench sets the wanted pin levels on want, one clock ahead.
`timescale 1ns/1ns
module dps_plant_model
  import dps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire dps_pin_type want,
  input  wire dps_act_type drive,
  output      dps_pin_type sense
);
  dps_pin_type sense_ff;

  assign sense = sense_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sense_ff <= '0;
      sense_ff.in5_closed <= 1'b1;
    end else begin
      sense_ff <= want;
      if (drive.out_cut) begin
        // Output cut: the motor coasts, so no ramp phase can be reported
        sense_ff.running <= 1'b0;
        sense_ff.accel <= 1'b0;
        sense_ff.decel <= 1'b0;
      end
    end
  end
endmodule

// ### tb/drive_protection_supervisor_test.sv
// Self-checking bench for the drive protection supervisor.
// Assumes dps_top and the far-side pin model; the APB master lives here.
`timescale 1ns/1ns
module drive_protection_supervisor_test;
  import dps_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        er;
  dps_pin_type want;
  dps_pin_type sense;
  dps_act_type drive;
  dps_cfg_type cfg;
  logic [7:0]  lvl;
  logic [15:0] cur;
  logic        hit;
  logic        acc;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  dps_top #(.TICK_CYCLES(10)) dut_u (.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SENSE(sense), .DRIVE(drive));
  dps_plant_model plant_u (.clk(clk), .arst_n(arst_n), .want(want), .drive(drive),
    .sense(sense));

  // --------------------------------
  // Clock, timeout and helpers
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The run needs about 1300 cycles; far beyond that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wcfg();
    apb(1'b1, OFS_CFG, {3'h0, cfg});
  endtask

  // Pins need one model flop, two sync flops and one output flop
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  function automatic logic over(input logic [15:0] c, input logic [7:0] l);
    return (32'(c) * 32'h64) > (32'(l) * 32'h3E8);
  endfunction

  // Pins are {run_cmd, running, accel, decel}
  task automatic rcase(input logic [4:0] code, input logic [3:0] p, input logic e);
    cfg.relay_fn = code;
    wcfg();
    {want.run_cmd, want.running, want.accel, want.decel} <= p;
    settle();
    chk("relay", 32'(drive.relay), 32'(e));
  endtask

  task automatic cut(input logic e);
    settle();
    chk("out_cut", 32'(drive.out_cut), 32'(e));
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    void'($urandom(32'h3816DAFE));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    want = '0;
    want.in5_closed = 1'b1;
    cfg = CFG_RST;
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    $display("test reset values and bus");
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", rd, {3'h0, CFG_RST});
    apb(1'b0, OFS_LIM, 32'h0);
    chk("lim", rd, {LIM_RST});
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    $display("test relay codes");
    rcase(RLY_STOPPED, 4'b0000, 1'b1);
    rcase(RLY_STOPPED, 4'b1000, 1'b0);
    rcase(RLY_STOPPED, 4'b0100, 1'b0);
    rcase(RLY_CONSTANT, 4'b1100, 1'b1);
    rcase(RLY_CONSTANT, 4'b1110, 1'b0);
    rcase(RLY_CONSTANT, 4'b1101, 1'b0);
    rcase(RLY_WAIT_RUN, 4'b0000, 1'b1);
    rcase(RLY_WAIT_RUN, 4'b1000, 1'b0);
    $display("test stall prevention");
    cfg.relay_fn = RLY_STALL;
    repeat (10) begin
      cfg.stall_mask = 3'($urandom_range(0, 7));
      lvl = 8'($urandom_range(30, 150));
      acc = 1'($urandom_range(0, 1));
      cur = 16'(lvl * 10);
      cur = $urandom_range(0, 1) ? cur + 16'($urandom_range(20, 250)) : cur - 16'h14;
      wcfg();
      apb(1'b1, OFS_LIM, {16'h03E8, lvl, 8'hB4});
      want.running <= 1'b1;
      want.accel <= acc;
      want.out_current <= cur;
      settle();
      hit = over(cur, lvl) && (acc ? cfg.stall_mask[0] : cfg.stall_mask[1]);
      chk("stall_decel", 32'(drive.stall_decel), 32'(hit));
      chk("stall relay", 32'(drive.relay), 32'(hit));
      if (acc) chk("ramp_extend", 32'(drive.ramp_extend), 32'(hit));
    end
    cfg.stall_mask = 3'h4;
    wcfg();
    want.out_current <= 16'h0;
    want.accel <= 1'b0;
    want.decel <= 1'b1;
    want.dc_link_high <= 1'b1;
    settle();
    chk("decel_hold", 32'(drive.decel_hold), 32'h1);
    chk("ramp_extend", 32'(drive.ramp_extend), 32'h1);
    want.dc_link_high <= 1'b0;
    settle();
    chk("decel_hold", 32'(drive.decel_hold), 32'h0);
    want.decel <= 1'b0;
    $display("test external trips");
    cfg.in4_fn = FN_EXT_NO;
    cfg.in5_fn = FN_EXT_NC;
    cfg.relay_fn = RLY_FAULT;
    wcfg();
    cut(1'b0);
    want.in4_closed <= 1'b1;
    cut(1'b1);
    chk("fault relay", 32'(drive.relay), 32'h1);
    want.in4_closed <= 1'b0;
    cut(1'b1);
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    want.in5_closed <= 1'b0;
    cut(1'b1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("nc trip", 32'(rd[TR_EXTB]), 32'h1);
    want.in5_closed <= 1'b1;
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    want.undervoltage <= 1'b1;
    settle();
    chk("uv relay", 32'(drive.relay), 32'h0);
    cfg.fault_mask = 3'h1;
    wcfg();
    settle();
    chk("uv relay", 32'(drive.relay), 32'h1);
    want.undervoltage <= 1'b0;
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    $display("test reference loss");
    cfg.relay_fn = RLY_REF_LOSS;
    cfg.loss_crit = CRIT_HALF;
    cfg.loss_action = ACT_COAST;
    wcfg();
    apb(1'b1, OFS_REF, {16'h03E8, 8'h00, 8'h32});
    want.ref_is_analog <= 1'b1;
    want.analog_pct <= 8'h1E;
    repeat (150) @(posedge clk);
    cut(1'b0);
    cfg.loss_crit = CRIT_MIN;
    wcfg();
    repeat (54) @(posedge clk);
    cut(1'b0);
    repeat (80) @(posedge clk);
    cut(1'b1);
    chk("loss relay", 32'(drive.relay), 32'h1);
    want.analog_pct <= 8'h50;
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    cfg.loss_action = ACT_DECEL;
    wcfg();
    want.ref_is_analog <= 1'b0;
    want.serial_ref_lost <= 1'b1;
    repeat (140) @(posedge clk);
    chk("stop_decel", 32'(drive.stop_decel), 32'h1);
    cut(1'b0);
    cfg.loss_action = 2'h0;
    wcfg();
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    chk("stop_decel", 32'(drive.stop_decel), 32'h0);
    want.serial_ref_lost <= 1'b0;
    $display("test user faults");
    cfg.user_mask = 3'h1;
    wcfg();
    want.in_phase_loss <= 1'b1;
    cut(1'b0);
    want.out_phase_loss <= 1'b1;
    cut(1'b1);
    {want.in_phase_loss, want.out_phase_loss} <= 2'h0;
    cfg.user_mask = 3'h6;
    wcfg();
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    want.in_phase_loss <= 1'b1;
    cut(1'b1);
    want.in_phase_loss <= 1'b0;
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    want.gnd_fault <= 1'b1;
    cut(1'b1);
    want.gnd_fault <= 1'b0;
    settle();
    apb(1'b1, OFS_CTRL, 32'h1);
    cut(1'b0);
    $display("test overloads");
    cfg.ovl_en = 1'b1;
    wcfg();
    apb(1'b1, OFS_TIM, {13'h0000, 11'h00A, 8'h02});
    want.out_current <= 16'h076C;
    repeat (150) @(posedge clk);
    cut(1'b0);
    repeat (60) @(posedge clk);
    cut(1'b1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("motor trip", 32'(rd[TR_DOL:TR_MOL]), 32'h1);
    cfg.ovl_en = 1'b0;
    cfg.relay_fn = RLY_DRV_OL;
    wcfg();
    apb(1'b1, OFS_CTRL, 32'h1);
    want.out_current <= 16'h07D0;
    repeat (100) @(posedge clk);
    cut(1'b0);
    chk("ol relay", 32'(drive.relay), 32'h0);
    want.out_current <= 16'hFFFF;
    repeat (60) @(posedge clk);
    cut(1'b1);
    chk("ol relay", 32'(drive.relay), 32'h1);
    cfg.relay_fn = RLY_FAULT;
    cfg.fault_mask = 3'h4;
    wcfg();
    settle();
    chk("tries relay", 32'(drive.relay), 32'h0);
    want.restart_tries <= 1'b1;
    settle();
    chk("tries relay", 32'(drive.relay), 32'h1);
    final_report();
  end
endmodule
